//--- src/reload_wdt_regs.svh
`ifndef RELOAD_WDT_REGS_SVH
`define RELOAD_WDT_REGS_SVH
`define CNT_OFS         8'h00
`define RLD_OFS         8'h04
`define CTL_OFS         8'h08
`define IRQ_OFS         8'h0C
`define CTL_RESET       8'h10
`define CTL_SEL_LSB     0
`define CTL_SEL_MSB     2
`define CTL_RUN_BIT     3
`define CTL_ONE_BIT     4
`define CTL_WRUN_BIT    5
`define CTL_NEXT_BIT    6
`define CTL_MODE_BIT    7
`define IRQ_FLAG_BIT    0
`define IRQ_EN_BIT      1
`define IRQ_PRI_LSB     2
`define IRQ_PRI_MSB     3
`define CODE_START      4'h3
`define CODE_ALT        4'hC
`define CNT_MAX         8'hFF
`define PRE_DIV_DEFAULT 1
`endif

//--- src/reload_wdt_pkg.sv
`default_nettype none
`include "reload_wdt_regs.svh"
package reload_wdt_pkg;
    typedef enum logic [2:0] {
        WD_OFF   = 3'b001,
        WD_ARMED = 3'b010,
        WD_RUN   = 3'b100
    } wd_phase_e;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        pend;
        logic        wr;
        logic [7:0]  addr;
        logic        ready;
        logic        resp;
        logic [31:0] rdata;
    } ahb_state_s;

    typedef struct packed {
        logic [7:0] pre;
        logic [7:0] div;
        logic       tick;
    } div_state_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] rld;
        logic [2:0] sel;
        logic       run;
        wd_phase_e  phase;
        logic       next_c;
        logic       flag;
        logic       en;
        logic [1:0] pri;
        logic       irq;
        logic       sys_rst;
    } core_state_s;
endpackage : reload_wdt_pkg
`default_nettype wire

//--- src/count_tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "reload_wdt_regs.svh"
module count_tick_divider
    import reload_wdt_pkg::*;
#(
    parameter int PRE_DIV = `PRE_DIV_DEFAULT
)(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [2:0] sel,
    output logic            tick
);
    div_state_s r;
    div_state_s nxt;

    // bit 8 flags a usable setting; codes 6 and 7 never tick
    function automatic logic [8:0] sel_mask(input logic [2:0] s);
        case (s)
            3'h0:    sel_mask = 9'h100;
            3'h1:    sel_mask = 9'h101;
            3'h2:    sel_mask = 9'h103;
            3'h3:    sel_mask = 9'h107;
            3'h4:    sel_mask = 9'h11F;
            3'h5:    sel_mask = 9'h1FF;
            default: sel_mask = 9'h000;
        endcase
    endfunction : sel_mask

    always_comb
    begin
        logic [8:0] m;
        m = sel_mask(sel);
        nxt = r;
        nxt.tick = 1'b0;
        if (r.pre == 8'(PRE_DIV - 1))
        begin
            nxt.pre = 8'h00;
            nxt.div = r.div + 8'h01;
            if (m[8] && ((r.div & m[7:0]) == m[7:0]))
                nxt.tick = 1'b1;
        end
        else
            nxt.pre = r.pre + 8'h01;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= nxt;
    end

    assign tick = r.tick;
endmodule : count_tick_divider
`default_nettype wire

//--- src/ahb_reg_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_slave
    import reload_wdt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output reg_req_s         req,
    input  wire logic [31:0] rd_data
);
    ahb_state_s r;
    ahb_state_s nxt;

    // one wait state per transfer so that a read never sees stale state
    // from a write still in its data phase
    always_comb
    begin
        nxt = r;
        if (r.pend)
        begin
            nxt.pend  = 1'b0;
            nxt.ready = 1'b1;
            if (!r.wr)
                nxt.rdata = rd_data;
        end
        else if (hsel && htrans[1] && hready)
        begin
            nxt.pend  = 1'b1;
            nxt.ready = 1'b0;
            nxt.wr    = hwrite;
            nxt.addr  = haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            r <= '{pend: 1'b0, wr: 1'b0, addr: 8'h00, ready: 1'b1,
                   resp: 1'b0, rdata: 32'h0000_0000};
        else
            r <= nxt;
    end

    assign hreadyout = r.ready;
    assign hresp     = r.resp;
    assign hrdata    = r.rdata;
    assign req       = '{valid: r.pend, wr: r.wr, addr: r.addr,
                         wdata: hwdata[7:0]};
endmodule : ahb_reg_slave
`default_nettype wire

//--- src/reload_timer_watchdog_8bit.sv
// Functional notes
// - 8-bit counter steps up by one per count tick while counting.
// - auto-reload overflow raises interrupt request and reloads counter.
// - watchdog overflow requests a whole-system reset.
// - watchdog only starts or reloads through special code writes.
// - running watchdog ignores value writes, counter still readable.
// - writing a counter value copies it into the reload register too.
// - reload register writable in auto mode, read-only in watchdog.
// - counter and reload contents undefined after any reset source.
// - control has eight bits; bits 4-6 not writable; bit 4 reads one.
// - control bits 0-2 choose the count clock.
// - bit 3 runs or halts auto-reload; watchdog just reads it back.
// - bit 5 reads one while watchdog counting runs.
// - alternate n3h and nCh writes reload the watchdog counter.
// - bit 6 shows which service code software must write next.
// - bit 7 selects mode: zero auto-reload, one watchdog.
// - after watchdog entry timeout-changing writes are ignored.
// - one control write sets mode and clock select together.
// - first n3h write starts watchdog without touching the counter.
// - watchdog mode is left only by a system reset.
// - auto-reload overflow sets flag; request gated by enable, priority is output only.
`timescale 1ns/1ps
`default_nettype none
`include "reload_wdt_regs.svh"
module reload_timer_watchdog_8bit
    import reload_wdt_pkg::*;
#(
    parameter int PRE_DIV = `PRE_DIV_DEFAULT
)(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq_req,
    output logic [1:0]       irq_priority,
    output logic             sys_reset_req
);
    // counter and reload are cleared here although software must not
    // rely on them after reset
    localparam core_state_s CORE_RESET = '{
        cnt:     8'h00,
        rld:     8'h00,
        sel:     3'h0,
        run:     1'b0,
        phase:   WD_OFF,
        next_c:  1'b0,
        flag:    1'b0,
        en:      1'b0,
        pri:     2'h0,
        irq:     1'b0,
        sys_rst: 1'b0
    };

    core_state_s s_r;
    core_state_s s_nxt;
    reg_req_s    req;
    logic        tick;
    logic [31:0] rd_data;
    logic        mode;
    logic        counting;
    logic        wr_cnt;
    logic        wr_rld;
    logic        wr_ctl;
    logic        wr_irq;
    logic [3:0]  want_code;

    ahb_reg_slave u_bus (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .req       (req),
        .rd_data   (rd_data)
    );

    count_tick_divider #(
        .PRE_DIV (PRE_DIV)
    ) u_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (s_r.sel),
        .tick    (tick)
    );

    function automatic logic [7:0] read_byte(input logic [7:0]  a,
                                             input core_state_s s);
        logic [7:0] c;
        c = 8'h00;
        c[`CTL_SEL_MSB:`CTL_SEL_LSB] = s.sel;
        c[`CTL_RUN_BIT]  = s.run;
        c[`CTL_ONE_BIT]  = 1'b1;
        c[`CTL_WRUN_BIT] = (s.phase == WD_RUN);
        c[`CTL_NEXT_BIT] = s.next_c;
        c[`CTL_MODE_BIT] = (s.phase != WD_OFF);
        case (a)
            `CNT_OFS: read_byte = s.cnt;
            `RLD_OFS: read_byte = s.rld;
            `CTL_OFS: read_byte = c;
            `IRQ_OFS: read_byte = {4'h0, s.pri, s.en, s.flag};
            default:  read_byte = 8'h00;
        endcase
    endfunction : read_byte

    assign rd_data   = {24'h00_0000, read_byte(req.addr, s_r)};
    assign mode      = (s_r.phase != WD_OFF);
    assign counting  = mode ? (s_r.phase == WD_RUN) : s_r.run;
    assign wr_cnt    = req.valid && req.wr && (req.addr == `CNT_OFS);
    assign wr_rld    = req.valid && req.wr && (req.addr == `RLD_OFS);
    assign wr_ctl    = req.valid && req.wr && (req.addr == `CTL_OFS);
    assign wr_irq    = req.valid && req.wr && (req.addr == `IRQ_OFS);
    assign want_code = s_r.next_c ? `CODE_ALT : `CODE_START;

    always_comb
    begin
        logic ovf_set;
        ovf_set = 1'b0;
        s_nxt = s_r;
        s_nxt.sys_rst = 1'b0;

        if (counting && tick)
        begin
            if (s_r.cnt == `CNT_MAX)
            begin
                s_nxt.cnt = s_r.rld;
                if (mode)
                    s_nxt.sys_rst = 1'b1;
                else
                    ovf_set = 1'b1;
            end
            else
                s_nxt.cnt = s_r.cnt + 8'h01;
        end
        if (ovf_set)
            s_nxt.flag = 1'b1;

        // a counter write lands after the count step, so the written value wins
        // over a tick in the same cycle; an overflow still sets the flag
        if (wr_cnt)
        begin
            if (!mode)
            begin
                s_nxt.cnt = req.wdata;
                s_nxt.rld = req.wdata;
            end
            else if (s_r.phase == WD_ARMED)
            begin
                if (req.wdata[3:0] == `CODE_START)
                begin
                    s_nxt.phase  = WD_RUN;
                    s_nxt.next_c = 1'b1;
                end
            end
            else if (req.wdata[3:0] == want_code)
            begin
                s_nxt.cnt    = s_r.rld;
                s_nxt.next_c = !s_r.next_c;
            end
            // any other write is dropped here
        end

        if (wr_rld && !mode)
            s_nxt.rld = req.wdata;

        if (wr_ctl)
        begin
            s_nxt.run = req.wdata[`CTL_RUN_BIT];
            if (!mode)
            begin
                s_nxt.sel = req.wdata[`CTL_SEL_MSB:`CTL_SEL_LSB];
                if (req.wdata[`CTL_MODE_BIT])
                    s_nxt.phase = WD_ARMED;
            end
        end

        if (wr_irq)
        begin
            if (req.wdata[`IRQ_FLAG_BIT])
                s_nxt.flag = ovf_set; // set wins over clear
            s_nxt.en  = req.wdata[`IRQ_EN_BIT];
            s_nxt.pri = req.wdata[`IRQ_PRI_MSB:`IRQ_PRI_LSB];
        end

        s_nxt.irq = s_nxt.flag && s_nxt.en;
    end

    // only the reset pin brings the phase back to WD_OFF
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= CORE_RESET;
        else
            s_r <= s_nxt;
    end

    assign irq_req       = s_r.irq;
    assign irq_priority  = s_r.pri;
    assign sys_reset_req = s_r.sys_rst;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_tick_step: assert property (
        (counting && tick && s_r.cnt != `CNT_MAX && !wr_cnt)
        |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
        else $error("counter did not step by one on a tick");

    a_ovf_reload: assert property (
        (!mode && s_r.run && tick && s_r.cnt == `CNT_MAX && !wr_cnt
         && !wr_rld && !wr_irq && !wr_ctl)
        |=> (s_r.cnt == $past(s_r.rld)) && s_r.flag)
        else $error("auto-reload overflow did not reload and flag");

    a_wdt_reset: assert property (
        (s_r.phase == WD_RUN && tick && s_r.cnt == `CNT_MAX)
        |=> sys_reset_req)
        else $error("watchdog overflow gave no system reset");

    a_reload_copy: assert property (
        (wr_cnt && !mode)
        |=> (s_r.cnt == $past(req.wdata)) && (s_r.rld == $past(req.wdata)))
        else $error("counter write not copied to reload");

    a_rld_locked: assert property (
        mode |=> $stable(s_r.rld))
        else $error("reload changed in watchdog mode");

    a_sel_locked: assert property (
        mode |=> $stable(s_r.sel) && (s_r.phase != WD_OFF))
        else $error("clock select or mode changed after watchdog entry");

    a_ctl_read: assert property (
        (req.valid && !req.wr && req.addr == `CTL_OFS)
        |=> hrdata[`CTL_ONE_BIT] && (hrdata[31:8] == 24'h00_0000))
        else $error("control read lost its fixed one bit");

    a_halt_hold: assert property (
        (!mode && !s_r.run && !wr_cnt) |=> $stable(s_r.cnt))
        else $error("halted counter moved");

    a_start_keep: assert property (
        (s_r.phase == WD_ARMED && wr_cnt && req.wdata[3:0] == `CODE_START)
        |=> (s_r.phase == WD_RUN) && $stable(s_r.cnt) && s_r.next_c)
        else $error("start code changed counter or did not start");

    a_service_load: assert property (
        (s_r.phase == WD_RUN && wr_cnt && req.wdata[3:0] == want_code)
        |=> (s_r.cnt == $past(s_r.rld)) && (s_r.next_c != $past(s_r.next_c)))
        else $error("service code did not reload the watchdog");

    a_bad_code: assert property (
        (s_r.phase == WD_RUN && wr_cnt && req.wdata[3:0] != want_code)
        |=> $stable(s_r.next_c))
        else $error("wrong service code advanced alternation");

    a_run_flag: assert property (
        (s_r.phase == WD_RUN) |-> rd_data[`CTL_WRUN_BIT]
        || (req.addr != `CTL_OFS))
        else $error("running flag not shown in watchdog run");

    // a reload of FFh on the fastest clock may pulse on every cycle, so
    // the single-pulse check only holds once the counter has left FFh
    a_rst_pulse: assert property (
        (sys_reset_req && s_r.cnt != `CNT_MAX) |=> !sys_reset_req)
        else $error("system reset request lasted more than one cycle");

    a_auto_no_rst: assert property (
        !mode |=> !sys_reset_req)
        else $error("auto-reload mode requested a system reset");

    a_irq_raise: assert property (
        (!mode && s_r.run && tick && s_r.cnt == `CNT_MAX
         && s_r.en && !wr_irq) |=> irq_req)
        else $error("enabled overflow did not raise the interrupt request");

    a_wdt_no_flag: assert property (
        (mode && !s_r.flag) |=> !s_r.flag)
        else $error("watchdog mode raised the overflow flag");

    a_flag_clear: assert property (
        (wr_irq && req.wdata[`IRQ_FLAG_BIT] && !tick) |=> !s_r.flag)
        else $error("writing one did not clear the overflow flag");

    a_prio_out: assert property (
        wr_irq
        |=> irq_priority == $past(req.wdata[`IRQ_PRI_MSB:`IRQ_PRI_LSB]))
        else $error("priority output does not follow its field");

    a_armed_hold: assert property (
        (s_r.phase == WD_ARMED
         && !(wr_cnt && req.wdata[3:0] == `CODE_START))
        |=> (s_r.phase == WD_ARMED) && $stable(s_r.cnt))
        else $error("armed watchdog moved without its start code");

    a_run_drop: assert property (
        (s_r.phase == WD_RUN && wr_cnt && req.wdata[3:0] != want_code
         && !tick) |=> $stable(s_r.cnt))
        else $error("running watchdog took an ordinary counter write");

    a_rld_write: assert property (
        (wr_rld && !mode) |=> s_r.rld == $past(req.wdata))
        else $error("reload write lost in auto-reload mode");

    a_hidden_bits: assert property (
        (!mode && req.valid && !req.wr && req.addr == `CTL_OFS)
        |=> hrdata[`CTL_NEXT_BIT:`CTL_WRUN_BIT] == 2'h0)
        else $error("status bits showed in auto-reload mode");

    a_next_show: assert property (
        (mode && req.valid && !req.wr && req.addr == `CTL_OFS)
        |=> hrdata[`CTL_NEXT_BIT] == $past(s_r.next_c))
        else $error("next code flag read back wrong");

    a_tick_gate: assert property (
        (!tick && !wr_cnt) |=> $stable(s_r.cnt))
        else $error("counter moved without a count tick");

    a_run_readback: assert property (
        (mode && wr_ctl) |=> s_r.run == $past(req.wdata[`CTL_RUN_BIT]))
        else $error("run bit did not keep its written value");

    a_sel_write: assert property (
        (!mode && wr_ctl)
        |=> (s_r.sel == $past(req.wdata[`CTL_SEL_MSB:`CTL_SEL_LSB]))
            && (mode == $past(req.wdata[`CTL_MODE_BIT])))
        else $error("control write did not set select and mode together");
endmodule : reload_timer_watchdog_8bit
`default_nettype wire

//--- tb/reload_timer_watchdog_8bit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reload_wdt_regs.svh"
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module reload_timer_watchdog_8bit_tb;
    logic        clk_sys       = 1'b0;
    logic        rst_n         = 1'b0;
    logic        hsel          = 1'b0;
    logic        hwrite        = 1'b0;
    logic [1:0]  htrans        = 2'h0;
    logic [2:0]  hsize         = 3'h2;
    logic [31:0] haddr         = 32'h0;
    logic [31:0] hwdata        = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq_req;
    logic [1:0]  irq_priority;
    logic        sys_reset_req;
    int          fails         = 0;
    int          total_checks  = 0;
    int          cyc           = 0;
    logic [7:0]  a;
    logic [7:0]  b;

    reload_timer_watchdog_8bit #(.PRE_DIV(1)) i_reload_timer_watchdog_8bit (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .hrdata        (hrdata),
        .irq_req       (irq_req),
        .irq_priority  (irq_priority),
        .sys_reset_req (sys_reset_req)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic close_out;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // a hang on the bus or a missing pulse must not stall the run
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end

    // entered just after a rising edge; leaves at the completing edge
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [7:0] wd, output logic [7:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, ad, wd, d);
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        bus(1'b0, ad, 8'h00, d);
    endtask : rd

    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, ad, 8'h00, d);
        `CHK(d, e)
    endtask : rdc

    task automatic t_reset;
        rdc(`CTL_OFS, `CTL_RESET);
        `CHK(irq_req, 1'b0)
        wr(`CTL_OFS, 8'h77);
        rdc(`CTL_OFS, 8'h17);
        wr(8'h10, 8'hFF);
        rdc(8'h10, 8'h00);
        `CHK(hresp, 1'b0)
        wr(`CTL_OFS, 8'h00);
        rdc(`CTL_OFS, 8'h10);
    endtask : t_reset

    task automatic t_auto;
        int i;
        wr(`CNT_OFS, 8'hF0);
        rdc(`RLD_OFS, 8'hF0);
        wr(`RLD_OFS, 8'hFA);
        rdc(`RLD_OFS, 8'hFA);
        rdc(`CNT_OFS, 8'hF0);
        wr(`IRQ_OFS, 8'h0E);
        `CHK(irq_priority, 2'h3)
        wr(`CTL_OFS, 8'h08);
        for (i = 0; i < 64 && irq_req !== 1'b1; i++) @(posedge clk_sys);
        `CHK(irq_req, 1'b1)
        wr(`CTL_OFS, 8'h00);
        rd(`CNT_OFS, a);
        `CHK((a >= 8'hFA), 1'b1)
        rdc(`CNT_OFS, a);
        wr(`CNT_OFS, 8'h00);
        wr(`CTL_OFS, 8'h08);
        rd(`CNT_OFS, a);
        rd(`CNT_OFS, b);
        `CHK(8'(b - a), 8'h03)
    endtask : t_auto

    // a 256-cycle window holds an exact number of ticks for every divisor
    task automatic t_select;
        logic [7:0] exp_d [8];
        exp_d = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h08, 8'h01, 8'h00, 8'h00};
        for (int s = 0; s < 8; s++)
        begin
            wr(`CNT_OFS, 8'h00);
            wr(`CTL_OFS, 8'h08 | 8'(s));
            rd(`CNT_OFS, a);
            repeat (253) @(posedge clk_sys);
            rd(`CNT_OFS, b);
            `CHK(8'(b - a), exp_d[s])
        end
        wr(`CTL_OFS, 8'h00);
    endtask : t_select

    task automatic t_irq;
        wr(`IRQ_OFS, 8'h0C);
        `CHK(irq_req, 1'b0)
        rdc(`IRQ_OFS, 8'h0D);
        wr(`IRQ_OFS, 8'h0D);
        rdc(`IRQ_OFS, 8'h0C);
        wr(`IRQ_OFS, 8'h0E);
    endtask : t_irq

    task automatic t_wdt;
        int i;
        wr(`CNT_OFS, 8'hF0);
        wr(`CTL_OFS, 8'h81);
        rdc(`CTL_OFS, 8'h91);
        wr(`CTL_OFS, 8'h0F);
        rdc(`CTL_OFS, 8'h99);
        wr(`RLD_OFS, 8'h11);
        rdc(`RLD_OFS, 8'hF0);
        wr(`CNT_OFS, 8'h55);
        rdc(`CNT_OFS, 8'hF0);
        wr(`CNT_OFS, 8'hA3);
        rd(`CNT_OFS, a);
        `CHK((a >= 8'hF0 && a <= 8'hF2), 1'b1)
        rdc(`CTL_OFS, 8'hF9);
        wr(`CNT_OFS, 8'h43);
        rdc(`CTL_OFS, 8'hF9);
        repeat (6) @(posedge clk_sys);
        wr(`CNT_OFS, 8'h0C);
        rd(`CNT_OFS, a);
        `CHK((a >= 8'hF0 && a <= 8'hF2), 1'b1)
        // read back soon enough that at most five ticks follow the service
        wr(`CNT_OFS, 8'h77);
        rd(`CNT_OFS, a);
        `CHK((a >= 8'hF0 && a <= 8'hF5), 1'b1)
        rdc(`CTL_OFS, 8'hB9);
        for (i = 0; i < 100 && sys_reset_req !== 1'b1; i++)
            @(posedge clk_sys);
        `CHK(sys_reset_req, 1'b1)
        @(posedge clk_sys);
        `CHK(sys_reset_req, 1'b0)
        // the device only requests; the system reset comes from outside
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(`CTL_OFS, `CTL_RESET);
    endtask : t_wdt

    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_auto();
        t_select();
        t_irq();
        t_wdt();
        close_out();
    end
endmodule : reload_timer_watchdog_8bit_tb
`default_nettype wire
